//--- src/pss_pkg.sv
// Shared constants and carriers for the port status page
package pss_pkg;
    // Speed ceiling codes; 110 and 111 are reserved
    localparam logic [2:0] SPD_S100 = 3'h0;
    localparam logic [2:0] SPD_S200 = 3'h1;
    localparam logic [2:0] SPD_S400 = 3'h2;
    localparam logic [2:0] SPD_S800 = 3'h3;
    localparam logic [2:0] SPD_S1600 = 3'h4;
    localparam logic [2:0] SPD_S3200 = 3'h5;

    // Register byte offsets
    localparam logic [7:0] OFS_PORT_SEL = 8'h00;
    localparam logic [7:0] OFS_PORT_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

    // Field positions in the port status word
    localparam int FLD_CEIL = 0;
    localparam int FLD_PLUG = 3;
    localparam int FLD_CAP = 4;
    localparam int FLD_UNREL = 7;
    localparam int FLD_BETA = 8;
    localparam int FLD_SLEEP = 9;
    localparam int FLD_SLEEP_DEFAULT_PIN = 10;
    localparam int FLD_CON = 11;
    localparam int FLD_RECEIVE_OK_INDICATOR = 12;
    localparam int FLD_LEGACY = 13;
    localparam int FLD_ERR = 16;

    // Interrupt status bits
    localparam int IRQ_UNREL = 0;
    localparam int IRQ_CODEERR = 1;
    localparam int IRQ_SLEEP = 2;
    localparam int IRQ_W = 3;

    // Reset values and limits
    localparam logic PLUG_PRESENT = 1'b1;
    localparam logic [7:0] ERR_MAX = 8'hFF;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // Connection debounce time
    localparam int DEBOUNCE_MS = 341;
    localparam int CLK_KHZ = 50_000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;

    // Per-port events from the port state logic, same clock
    typedef struct packed {
        logic beta_link;    // Port trained in beta signaling
        logic signal_valid; // Continuous valid beta signal
        logic tones_only;   // Only connection tones seen
        logic bias_ok;      // Debounced bias seen, legacy mode
        logic nego_fail;    // Beta speed negotiation failed
        logic sync_fail;    // Synchronization failed
        logic bad_codeword; // Invalid code word received
        logic sleep_req;    // Port wants to enter sleep
        logic wake_req;     // Port leaves sleep
        logic new_conn;     // New connection established
    } pss_port_ev_t;

    // Bus data phase tracking
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_READ = 3'b010,
        BUS_WRITE = 3'b100
    } pss_bus_st_t;
endpackage

//--- src/pss_port_status.sv
// Contract
// - Speed ceiling is three bits: 000 S100 up to 101 S3200, 110/111 reserved.
// - Ceiling writes above port capability store the port's highest speed instead.
// - Ceiling is consulted only on a new beta connection of a beta-only port.
// - Bilingual ports hold beta speed at S400 and ignore ceiling writes.
// - At power reset each beta-only ceiling loads the port's highest capable speed; bilingual ones load S400.
// - Software may lower a beta-only ceiling, never below the minimum speed.
// - Plug-present flag always reads one for every port.
// - Read-only three-bit field reports each port's highest beta speed.
// - Unreliable flag sets on beta speed negotiation or synchronization failure.
// - Writing one clears the unreliable flag; writing zero leaves it.
// - Beta indicator is one in beta mode, zero in legacy or disconnected.
// - Legacy active exactly when connected, receive ok and beta indicator zero.
// - Eight-bit invalid code word counter increments, saturating at 255.
// - Error counter clears on any read, local or remote.
// - Sleep flag is set while asleep; sleep entered only when enabled.
// - Connected bit sets after 341 ms stable; hardware reset clears it.
// - Beta receive ok means continuous valid signal, false during tones only.
// - Per-port sleep enable is writable, initialised from a pin at reset.
`timescale 1ns/1ps
`default_nettype none
module pss_port_status #(
    parameter int NPORTS = 3,
    parameter int DEBOUNCE_CYCLES = pss_pkg::DEBOUNCE_CYCLES,
    parameter logic [2:0] MIN_SPEED = pss_pkg::SPD_S100,
    localparam int PW = $clog2(NPORTS),
    localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1)
) (
    input wire logic hclk, // Bus clock, 50 MHz
    input wire logic hresetn, // Async reset, active low
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [31:0] hrdata, // Read data
    output logic hresp, // Always OKAY
    input wire logic [NPORTS-1:0] port_connect_pin, // Raw connection detect
    input wire logic [NPORTS-1:0][2:0] port_cap_pin, // Speed capability strap
    input wire logic [NPORTS-1:0] port_bilingual_pin, // Bilingual strap
    input wire logic sleep_default_pin, // Sleep enable strap
    input wire pss_pkg::pss_port_ev_t [NPORTS-1:0] port_ev, // Port events
    input wire logic remote_rd, // Remote access read pulse
    input wire logic [PW-1:0] remote_port, // Port of remote read
    output logic [7:0] remote_rd_count, // Counter value of remote read
    output logic remote_rd_valid, // Remote read answer pulse
    output logic [NPORTS-1:0][2:0] train_speed, // Speed for training
    output logic [NPORTS-1:0] port_asleep, // Sleep state per port
    output logic irq // Level interrupt
);
    // Parameters the logic cannot serve
    if (NPORTS < 2 || NPORTS > 16) begin : g_chk_ports
        $error("NPORTS must be 2 to 16");
    end
    if (DEBOUNCE_CYCLES < 1 || MIN_SPEED > pss_pkg::SPD_S3200) begin : g_chk_misc
        $error("bad debounce or minimum speed");
    end

    // Write value clamped into [MIN_SPEED, capability]
    function automatic logic [2:0] clamp_speed(input logic [2:0] wr, input logic [2:0] cap);
        logic [2:0] v;
        v = wr;
        if (v > cap || v > pss_pkg::SPD_S3200) begin
            v = cap;
        end
        if (v < MIN_SPEED) begin
            v = MIN_SPEED;
        end
        return v;
    endfunction

    logic [NPORTS-1:0] con_s1_reg, con_s2_reg;
    logic [NPORTS-1:0][2:0] cap_s1_reg, cap_s2_reg, cap_reg;
    logic [NPORTS-1:0] bil_s1_reg, bil_s2_reg, bil_reg;
    logic slp_s1_reg, slp_s2_reg;
    logic [1:0] strap_cnt_reg;
    logic strap_done_reg;
    logic [NPORTS-1:0][2:0] ceil_reg;
    logic [NPORTS-1:0][DBW-1:0] db_cnt_reg;
    logic [NPORTS-1:0] con_reg, receive_ok_indicator_reg, beta_reg, unrel_reg, sleep_default_pin_reg;
    logic [NPORTS-1:0][7:0] err_reg;
    logic [PW-1:0] sel_reg;
    logic [pss_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
    pss_pkg::pss_bus_st_t bus_st_reg;
    logic [7:0] wr_addr_reg;
    logic [NPORTS-1:0] rd_clr, wr_stat;
    logic [pss_pkg::IRQ_W-1:0] irq_ev;
    logic acc, acc_rd, acc_wr;

    // Status word of one port
    function automatic logic [31:0] stat_word(input logic [PW-1:0] p);
        logic [31:0] w;
        w = 32'h0;
        w[pss_pkg::FLD_CEIL +: 3] = ceil_reg[p];
        w[pss_pkg::FLD_PLUG] = pss_pkg::PLUG_PRESENT;
        w[pss_pkg::FLD_CAP +: 3] = cap_reg[p];
        w[pss_pkg::FLD_UNREL] = unrel_reg[p];
        w[pss_pkg::FLD_BETA] = beta_reg[p];
        w[pss_pkg::FLD_SLEEP] = port_asleep[p];
        w[pss_pkg::FLD_SLEEP_DEFAULT_PIN] = sleep_default_pin_reg[p];
        w[pss_pkg::FLD_CON] = con_reg[p];
        w[pss_pkg::FLD_RECEIVE_OK_INDICATOR] = receive_ok_indicator_reg[p];
        w[pss_pkg::FLD_LEGACY] = con_reg[p] & receive_ok_indicator_reg[p] & ~beta_reg[p];
        w[pss_pkg::FLD_ERR +: 8] = err_reg[p];
        return w;
    endfunction

    // Address phase decode; only word transfers are taken
    assign acc = hsel & htrans[1] & hready & (hsize == 3'h2);
    assign acc_rd = acc & ~hwrite;
    assign acc_wr = acc & hwrite;

    // Pin synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            con_s1_reg <= '0;
            con_s2_reg <= '0;
            cap_s1_reg <= '0;
            cap_s2_reg <= '0;
            bil_s1_reg <= '0;
            bil_s2_reg <= '0;
            slp_s1_reg <= 1'b0;
            slp_s2_reg <= 1'b0;
        end else if (ce) begin
            con_s1_reg <= port_connect_pin;
            con_s2_reg <= con_s1_reg;
            cap_s1_reg <= port_cap_pin;
            cap_s2_reg <= cap_s1_reg;
            bil_s1_reg <= port_bilingual_pin;
            bil_s2_reg <= bil_s1_reg;
            slp_s1_reg <= sleep_default_pin;
            slp_s2_reg <= slp_s1_reg;
        end
    end

    // Strap capture once the synchronisers have settled after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            cap_reg <= '0;
            bil_reg <= '0;
        end else if (ce && !strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == 2'h2) begin
                strap_done_reg <= 1'b1;
                cap_reg <= cap_s2_reg;
                bil_reg <= bil_s2_reg;
            end
        end
    end

    // Bus data phase state; every access answers with zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st_reg <= pss_pkg::BUS_IDLE;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            case (1'b1)
                acc_rd: begin
                    bus_st_reg <= pss_pkg::BUS_READ;
                    // Upper address bits must be zero, else the read lands on no register
                    case ((haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF)
                        pss_pkg::OFS_PORT_SEL: hrdata <= {{(32-PW){1'b0}}, sel_reg};
                        pss_pkg::OFS_PORT_STAT: hrdata <= stat_word(sel_reg);
                        pss_pkg::OFS_IRQ_STAT: hrdata <= {{(32-pss_pkg::IRQ_W){1'b0}}, irq_stat_reg};
                        pss_pkg::OFS_IRQ_MASK: hrdata <= {{(32-pss_pkg::IRQ_W){1'b0}}, irq_mask_reg};
                        default: hrdata <= 32'h0;
                    endcase
                end
                acc_wr: begin
                    bus_st_reg <= pss_pkg::BUS_WRITE;
                    wr_addr_reg <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
                end
                default: bus_st_reg <= pss_pkg::BUS_IDLE;
            endcase
        end
    end

    // Per-port strobes: read clear of the counter, write of the status word
    always_comb begin
        for (int p = 0; p < NPORTS; p++) begin
            rd_clr[p] = (acc_rd && haddr[31:0] == {24'h0, pss_pkg::OFS_PORT_STAT}
                && sel_reg == PW'(p)) || (remote_rd && remote_port == PW'(p));
            wr_stat[p] = bus_st_reg == pss_pkg::BUS_WRITE
                && wr_addr_reg == pss_pkg::OFS_PORT_STAT && sel_reg == PW'(p);
        end
    end

    // Port select and interrupt mask writes; out-of-range ports are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_reg <= '0;
            irq_mask_reg <= pss_pkg::IRQ_MASK_RST;
        end else if (ce && bus_st_reg == pss_pkg::BUS_WRITE) begin
            if (wr_addr_reg == pss_pkg::OFS_PORT_SEL && hwdata[31:0] < 32'(NPORTS)) begin
                sel_reg <= hwdata[PW-1:0];
            end
            if (wr_addr_reg == pss_pkg::OFS_IRQ_MASK) begin
                sel_reg <= sel_reg;
                irq_mask_reg <= hwdata[pss_pkg::IRQ_W-1:0];
            end
        end
    end

    // Speed ceiling: loaded from capability, clamped writes, bilingual fixed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ceil_reg <= '0;
        end else if (ce) begin
            for (int p = 0; p < NPORTS; p++) begin
                if (!strap_done_reg) begin
                    ceil_reg[p] <= bil_s2_reg[p] ? pss_pkg::SPD_S400 : cap_s2_reg[p];
                end else if (bil_reg[p]) begin
                    ceil_reg[p] <= pss_pkg::SPD_S400;
                end else if (wr_stat[p]) begin
                    ceil_reg[p] <= clamp_speed(hwdata[pss_pkg::FLD_CEIL +: 3], cap_reg[p]);
                end
            end
        end
    end

    // Training speed latched only when a new beta connection forms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            train_speed <= '0;
        end else if (ce) begin
            for (int p = 0; p < NPORTS; p++) begin
                if (port_ev[p].new_conn && port_ev[p].beta_link) begin
                    train_speed[p] <= bil_reg[p] ? pss_pkg::SPD_S400 : ceil_reg[p];
                end
            end
        end
    end

    // Connection debounce; loss of connection drops it at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            db_cnt_reg <= '0;
            con_reg <= '0;
        end else if (ce) begin
            for (int p = 0; p < NPORTS; p++) begin
                if (!con_s2_reg[p]) begin
                    db_cnt_reg[p] <= '0;
                    con_reg[p] <= 1'b0;
                end else if (db_cnt_reg[p] == DBW'(DEBOUNCE_CYCLES - 1)) begin
                    con_reg[p] <= 1'b1;
                end else begin
                    db_cnt_reg[p] <= db_cnt_reg[p] + DBW'(1);
                end
            end
        end
    end

    // Receive ok and beta indicator follow the connection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            receive_ok_indicator_reg <= '0;
            beta_reg <= '0;
        end else if (ce) begin
            for (int p = 0; p < NPORTS; p++) begin
                receive_ok_indicator_reg[p] <= con_reg[p] & (port_ev[p].beta_link
                    ? (port_ev[p].signal_valid & ~port_ev[p].tones_only)
                    : port_ev[p].bias_ok);
                beta_reg[p] <= con_reg[p] & port_ev[p].beta_link;
            end
        end
    end

    // Unreliable flag; a failure in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unrel_reg <= '0;
        end else if (ce) begin
            for (int p = 0; p < NPORTS; p++) begin
                if (port_ev[p].nego_fail || port_ev[p].sync_fail) begin
                    unrel_reg[p] <= 1'b1;
                end else if (wr_stat[p] && hwdata[pss_pkg::FLD_UNREL]) begin
                    unrel_reg[p] <= 1'b0;
                end
            end
        end
    end

    // Error counter; a code error in the read cycle is kept as one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_reg <= '0;
        end else if (ce) begin
            for (int p = 0; p < NPORTS; p++) begin
                if (rd_clr[p]) begin
                    err_reg[p] <= {7'h00, port_ev[p].bad_codeword};
                end else if (port_ev[p].bad_codeword && err_reg[p] != pss_pkg::ERR_MAX) begin
                    err_reg[p] <= err_reg[p] + 8'h01;
                end
            end
        end
    end

    // Remote read answer, one cycle after the request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remote_rd_count <= 8'h00;
            remote_rd_valid <= 1'b0;
        end else if (ce) begin
            remote_rd_valid <= remote_rd;
            if (remote_rd) begin
                // A port number past the last port answers zero, not an unknown
                remote_rd_count <= (int'(remote_port) < NPORTS) ? err_reg[remote_port] : 8'h00;
            end
        end
    end

    // Sleep enable from the strap, then software; sleep entry gated by it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_default_pin_reg <= '0;
            port_asleep <= '0;
        end else if (ce) begin
            for (int p = 0; p < NPORTS; p++) begin
                if (!strap_done_reg) begin
                    sleep_default_pin_reg[p] <= slp_s2_reg;
                end else if (wr_stat[p]) begin
                    sleep_default_pin_reg[p] <= hwdata[pss_pkg::FLD_SLEEP_DEFAULT_PIN];
                end
                if (port_ev[p].wake_req) begin
                    port_asleep[p] <= 1'b0;
                end else if (port_ev[p].sleep_req && sleep_default_pin_reg[p]) begin
                    port_asleep[p] <= 1'b1;
                end
            end
        end
    end

    // Interrupt events from any port
    always_comb begin
        irq_ev = '0;
        for (int p = 0; p < NPORTS; p++) begin
            irq_ev[pss_pkg::IRQ_UNREL] |= port_ev[p].nego_fail | port_ev[p].sync_fail;
            irq_ev[pss_pkg::IRQ_CODEERR] |= port_ev[p].bad_codeword;
            irq_ev[pss_pkg::IRQ_SLEEP] |= port_ev[p].sleep_req & sleep_default_pin_reg[p]
                & ~port_asleep[p] & ~port_ev[p].wake_req;
        end
    end

    // Sticky status, write one to clear, new events win
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            if (bus_st_reg == pss_pkg::BUS_WRITE && wr_addr_reg == pss_pkg::OFS_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~hwdata[pss_pkg::IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_ev;
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Checks per port
    for (genvar g = 0; g < NPORTS; g++) begin : g_chk
        plug_reads_one_a: assert property (acc_rd && ce && sel_reg == PW'(g)
            && haddr == {24'h0, pss_pkg::OFS_PORT_STAT} |=> hrdata[pss_pkg::FLD_PLUG])
            else $error("plug flag read as zero");
        ceil_in_range_a: assert property (strap_done_reg && !bil_reg[g]
            |-> ceil_reg[g] <= cap_reg[g] && ceil_reg[g] >= MIN_SPEED)
            else $error("ceiling outside range");
        bil_fixed_a: assert property (strap_done_reg && bil_reg[g] && ce
            |=> ceil_reg[g] == pss_pkg::SPD_S400)
            else $error("bilingual ceiling moved");
        unrel_set_a: assert property (ce && port_ev[g].nego_fail |=> unrel_reg[g])
            else $error("unreliable flag not set");
        unrel_clear_a: assert property (ce && wr_stat[g] && hwdata[pss_pkg::FLD_UNREL]
            && !port_ev[g].nego_fail && !port_ev[g].sync_fail |=> !unrel_reg[g])
            else $error("unreliable flag not cleared");
        beta_needs_con_a: assert property (beta_reg[g] |-> $past(con_reg[g]))
            else $error("beta indicator without connection");
        err_saturates_a: assert property (ce && err_reg[g] == pss_pkg::ERR_MAX && !rd_clr[g]
            |=> err_reg[g] == pss_pkg::ERR_MAX)
            else $error("error counter wrapped");
        err_read_clr_a: assert property (ce && rd_clr[g] && !port_ev[g].bad_codeword
            |=> err_reg[g] == 8'h00)
            else $error("error counter not cleared by read");
        sleep_gated_a: assert property ($rose(port_asleep[g]) |-> $past(sleep_default_pin_reg[g]))
            else $error("sleep entered while disabled");
        con_drop_a: assert property (ce && !con_s2_reg[g] |=> !con_reg[g])
            else $error("connected without stable pin");
        receive_ok_indicator_tones_a: assert property (ce && port_ev[g].beta_link && port_ev[g].tones_only
            |=> !receive_ok_indicator_reg[g])
            else $error("receive ok during tones");
    end
endmodule
`default_nettype wire

//--- verif/pss_port_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pss_port_status_tb;
    localparam int NP = 3;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [NP-1:0] con_pin = 3'h0;
    logic [NP-1:0][2:0] cap_pin = {3'h2, 3'h5, 3'h3};
    logic [NP-1:0] bil_pin = 3'h4;
    pss_pkg::pss_port_ev_t [NP-1:0] ev = '0;
    logic remote_rd = 1'h0;
    logic [1:0] remote_port = 2'h0;
    logic ce_tb = 1'h1;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic [7:0] rr_count;
    wire logic rr_valid;
    wire logic [NP-1:0][2:0] train_speed;
    wire logic [NP-1:0] port_asleep;
    wire logic irq;
    int mismatches = 0;
    int num_checks = 0;
    logic [15:0] lfsr = 16'h7FEB;
    logic [31:0] rd;
    logic [2:0] ceil_e [NP];

    // Short debounce keeps the run brief
    pss_port_status #(.NPORTS(NP), .DEBOUNCE_CYCLES(8)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .ce(ce_tb), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .port_connect_pin(con_pin), .port_cap_pin(cap_pin),
        .port_bilingual_pin(bil_pin), .sleep_default_pin(1'h1), .port_ev(ev),
        .remote_rd(remote_rd), .remote_port(remote_port), .remote_rd_count(rr_count),
        .remote_rd_valid(rr_valid), .train_speed(train_speed),
        .port_asleep(port_asleep), .irq(irq));

    // Clock, 20 ns period
    always #10 hclk = ~hclk;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Bilingual ports ignore writes; others clamp to capability
    function automatic logic [2:0] exp_ceil(input logic [2:0] v, input int p);
        if (bil_pin[p]) return 3'h2;
        if (v > cap_pin[p]) return cap_pin[p];
        return v;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single transfer; extra edge after writes lets delayed updates land
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        chk({hreadyout, hresp}, 2'h2);
        if (wr) @(posedge hclk);
    endtask

    task automatic stat(input int p);
        bus(1'h1, pss_pkg::OFS_PORT_SEL, p);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
    endtask

    // Bit index follows the event struct layout, new_conn at bit 0
    task automatic pulse(input int p, input int b);
        ev[p][b] <= 1'h1;
        @(posedge hclk);
        ev[p][b] <= 1'h0;
        @(posedge hclk);
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        final_report;
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (6) @(posedge hclk);
        for (int p = 0; p < NP; p++) begin
            stat(p);
            ceil_e[p] = bil_pin[p] ? 3'h2 : cap_pin[p];
            chk(rd[2:0], ceil_e[p]);
            chk(rd[6:3], {cap_pin[p], 1'h1});
            chk(rd[10], 1'h1);
        end
        // Random ceilings, reserved codes included; bit 10 keeps sleep enabled
        for (int i = 0; i < 15; i++) begin
            lfsr = lfsr_next(lfsr);
            bus(1'h1, pss_pkg::OFS_PORT_SEL, i % NP);
            bus(1'h1, pss_pkg::OFS_PORT_STAT, {29'h80, lfsr[2:0]});
            ceil_e[i % NP] = exp_ceil(lfsr[2:0], i % NP);
            bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
            chk(rd[3:0], {1'h1, ceil_e[i % NP]});
        end
        for (int p = 0; p < NP; p++) begin
            ev[p].beta_link <= 1'h1;
            pulse(p, 0);
            chk(train_speed[p], ceil_e[p]);
            ev[p].beta_link <= 1'h0;
        end
        // Unreliable flag: set by failures, write one clears, interrupt path
        bus(1'h1, pss_pkg::OFS_PORT_SEL, 1);
        pulse(1, 5);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk(rd[7], 1'h1);
        chk(irq, 1'h0);
        bus(1'h1, pss_pkg::OFS_PORT_STAT, {29'h80, ceil_e[1]});
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk(rd[7], 1'h1);
        bus(1'h1, pss_pkg::OFS_PORT_STAT, {29'h90, ceil_e[1]});
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk(rd[7], 1'h0);
        pulse(1, 4);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk(rd[7], 1'h1);
        bus(1'h1, pss_pkg::OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk(irq, 1'h1);
        bus(1'h1, pss_pkg::OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge hclk);
        chk(irq, 1'h0);
        // Error counter: count, clear on read, saturate
        lfsr = lfsr_next(lfsr);
        stat(2);
        repeat (lfsr[3:0] + 1) pulse(2, 3);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk(rd[23:16], lfsr[3:0] + 8'h1);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk(rd[23:16], 8'h0);
        ev[2].bad_codeword <= 1'h1;
        repeat (260) @(posedge hclk);
        ev[2].bad_codeword <= 1'h0;
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk(rd[23:16], 8'hFF);
        // Remote read of port 0 clears its counter too
        repeat (3) pulse(0, 3);
        remote_rd <= 1'h1;
        @(posedge hclk);
        remote_rd <= 1'h0;
        #1;
        chk({rr_valid, rr_count}, 9'h103);
        @(posedge hclk);
        stat(0);
        chk(rd[23:16], 8'h0);
        // Connection, beta and legacy indicators on port 0
        con_pin[0] <= 1'h1;
        ev[0].beta_link <= 1'h1;
        ev[0].signal_valid <= 1'h1;
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk(rd[11], 1'h0);
        repeat (16) @(posedge hclk);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk({rd[13:11], rd[8]}, 4'h7);
        ev[0].tones_only <= 1'h1;
        repeat (3) @(posedge hclk);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk({rd[13:11], rd[8]}, 4'h3);
        ev[0].beta_link <= 1'h0;
        ev[0].bias_ok <= 1'h1;
        repeat (3) @(posedge hclk);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk({rd[13:11], rd[8]}, 4'hE);
        con_pin[0] <= 1'h0;
        repeat (4) @(posedge hclk);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk({rd[13:11], rd[8]}, 4'h0);
        // Sleep entry, wake, and refusal once disabled
        pulse(0, 2);
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk({port_asleep[0], rd[9]}, 2'h3);
        pulse(0, 1);
        chk(port_asleep[0], 1'h0);
        bus(1'h1, pss_pkg::OFS_PORT_STAT, {29'h0, ceil_e[0]});
        pulse(0, 2);
        chk(port_asleep[0], 1'h0);
        // Clock enable low freezes the counter while a code error arrives
        ce_tb <= 1'h0;
        pulse(0, 3);
        ce_tb <= 1'h1;
        bus(1'h0, pss_pkg::OFS_PORT_STAT, 32'h0);
        chk(rd[23:16], 8'h0);
        final_report;
    end
endmodule
`default_nettype wire
